// ---- hw/sbrg_pkg.sv ----
/*
 * sbrg_pkg: constants and state layout of the serial bit-rate divider.
 * assumes a 32-bit avalon-mm slave port with byte addresses, one word
 * per register.
 */
package sbrg_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam int ADDR_W = 5;
	localparam logic [4:0] OFF_DIV_LOW = 5'h00;
	localparam logic [4:0] OFF_DIV_HIGH = 5'h04;
	localparam logic [4:0] OFF_TSC = 5'h08;
	localparam logic [4:0] OFF_BCON = 5'h0C;
	localparam logic [4:0] OFF_COUNT = 5'h10;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int TSC_SYNC_BIT = 4;
	localparam int TSC_HS_BIT = 2;
	localparam int BCON_WIDE_BIT = 3;

	// ------------------------------------------------------------
	// reset values and writable masks
	// ------------------------------------------------------------
	localparam logic [7:0] DIV_LOW_RST = 8'h00;
	localparam logic [7:0] DIV_HIGH_RST = 8'h00;
	localparam logic [7:0] TSC_RST = 8'h02;
	localparam logic [7:0] TSC_WMASK = 8'hFD;
	localparam logic [7:0] BCON_RST = 8'h40;
	localparam logic [7:0] BCON_WMASK = 8'h9B;

	// ------------------------------------------------------------
	// prescale terminal counts (prescale minus one)
	// ------------------------------------------------------------
	localparam logic [5:0] PRE_64_MAX = 6'h3F;
	localparam logic [5:0] PRE_16_MAX = 6'h0F;
	localparam logic [5:0] PRE_4_MAX = 6'h03;

	typedef struct packed {
		logic [7:0] div_low;
		logic [7:0] div_high;
		logic [7:0] tsc;
		logic [7:0] bcon;
		logic [5:0] pre_cnt;
		logic [15:0] div_cnt;
		logic tick;
		logic wait_req;
		logic [31:0] rdata;
		logic sync_mode;
		logic wide_div;
		logic high_speed;
	} sbrg_state_s;

endpackage

// ---- hw/sbrg_top.sv ----
/*
 * sbrg_top: bit-rate divider of the enhanced serial port with its
 * divisor and mode registers behind an avalon-mm slave.
 * assumes one 100 MHz clock, synchronous active-high reset, and a
 * master that holds each request until waitrequest is seen low.
 */
// Notes on behaviour
// - divisor low byte is a read-write register cleared at reset.
// - a write to the divisor low byte restarts the divider counter.
// - divisor high byte is a read-write register cleared at reset.
// - a write to the divisor high byte also restarts the divider counter.
// - the high byte is ignored unless the wide divisor select is set.
// - the wide divisor is the high byte joined above the low byte.
// - async, narrow, low speed gives clock over 64 times divisor plus one.
// - async, wide, low speed gives clock over 16 times divisor plus one.
// - sync mode gives clock over 4 times divisor plus one, any speed select.
// - sync select is bit 4 and high speed select bit 2 of the tx control.
// - wide divisor select is bit 3 of the baud control register.
// - wide select one uses 16 divisor bits, zero uses 8.
// - mode select one means synchronous, zero asynchronous.
`timescale 1ns/1ps

module sbrg_top (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic ce_in,
	input wire logic [sbrg_pkg::ADDR_W-1:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	output logic bit_tick_out,
	output logic sync_mode_out,
	output logic wide_div_out,
	output logic high_speed_out
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	sbrg_pkg::sbrg_state_s st_reg;
	sbrg_pkg::sbrg_state_s st_next;

	logic req;
	logic take;
	logic wr_low;
	logic wr_high;
	logic wr_tsc;
	logic wr_bcon;
	logic mode_sync;
	logic mode_wide;
	logic mode_hs;
	logic [15:0] eff_div;
	logic [5:0] pre_max;
	logic pre_end;
	logic div_end;

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	assign req = avs_read_in | avs_write_in;
	assign take = req & ~st_reg.wait_req;
	assign wr_low = take & avs_write_in & avs_byteenable_in[0]
		& (avs_address_in == sbrg_pkg::OFF_DIV_LOW);
	assign wr_high = take & avs_write_in & avs_byteenable_in[0]
		& (avs_address_in == sbrg_pkg::OFF_DIV_HIGH);
	assign wr_tsc = take & avs_write_in & avs_byteenable_in[0]
		& (avs_address_in == sbrg_pkg::OFF_TSC);
	assign wr_bcon = take & avs_write_in & avs_byteenable_in[0]
		& (avs_address_in == sbrg_pkg::OFF_BCON);

	// ------------------------------------------------------------
	// mode selection
	// ------------------------------------------------------------
	assign mode_sync = st_reg.tsc[sbrg_pkg::TSC_SYNC_BIT];
	assign mode_hs = st_reg.tsc[sbrg_pkg::TSC_HS_BIT];
	assign mode_wide = st_reg.bcon[sbrg_pkg::BCON_WIDE_BIT];

	// narrow mode drops the high byte
	assign eff_div = mode_wide ? {st_reg.div_high, st_reg.div_low}
		: {8'h00, st_reg.div_low};

	always_comb begin
		if (mode_sync) begin
			pre_max = sbrg_pkg::PRE_4_MAX;
		end else if (mode_wide && mode_hs) begin
			pre_max = sbrg_pkg::PRE_4_MAX;
		end else if (mode_wide || mode_hs) begin
			pre_max = sbrg_pkg::PRE_16_MAX;
		end else begin
			pre_max = sbrg_pkg::PRE_64_MAX;
		end
	end

	assign pre_end = (st_reg.pre_cnt >= pre_max);
	assign div_end = (st_reg.div_cnt >= eff_div);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		st_next.tick = 1'b0;
		// one wait cycle, then the answer stands for one cycle
		st_next.wait_req = ~(req & st_reg.wait_req);
		if (req && st_reg.wait_req) begin
			unique case (avs_address_in)
				sbrg_pkg::OFF_DIV_LOW: st_next.rdata = {24'h000000, st_reg.div_low};
				sbrg_pkg::OFF_DIV_HIGH: st_next.rdata = {24'h000000, st_reg.div_high};
				sbrg_pkg::OFF_TSC: st_next.rdata = {24'h000000, st_reg.tsc};
				sbrg_pkg::OFF_BCON: st_next.rdata = {24'h000000, st_reg.bcon};
				sbrg_pkg::OFF_COUNT: st_next.rdata = {16'h0000, st_reg.div_cnt};
				default: st_next.rdata = 32'h00000000;
			endcase
		end
		if (wr_low) begin
			st_next.div_low = avs_writedata_in[7:0];
		end
		if (wr_high) begin
			st_next.div_high = avs_writedata_in[7:0];
		end
		if (wr_tsc) begin
			st_next.tsc = (st_reg.tsc & ~sbrg_pkg::TSC_WMASK)
				| (avs_writedata_in[7:0] & sbrg_pkg::TSC_WMASK);
		end
		if (wr_bcon) begin
			st_next.bcon = (st_reg.bcon & ~sbrg_pkg::BCON_WMASK)
				| (avs_writedata_in[7:0] & sbrg_pkg::BCON_WMASK);
		end
		// divider: prescale counter feeds the divisor counter
		if (wr_low || wr_high) begin
			st_next.pre_cnt = 6'h00;
			st_next.div_cnt = 16'h0000;
		end else if (pre_end) begin
			st_next.pre_cnt = 6'h00;
			if (div_end) begin
				st_next.div_cnt = 16'h0000;
				st_next.tick = 1'b1;
			end else begin
				st_next.div_cnt = st_reg.div_cnt + 16'h0001;
			end
		end else begin
			st_next.pre_cnt = st_reg.pre_cnt + 6'h01;
		end
		st_next.sync_mode = mode_sync;
		st_next.wide_div = mode_wide;
		st_next.high_speed = mode_hs;
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			st_reg.div_low <= sbrg_pkg::DIV_LOW_RST;
			st_reg.div_high <= sbrg_pkg::DIV_HIGH_RST;
			st_reg.tsc <= sbrg_pkg::TSC_RST;
			st_reg.bcon <= sbrg_pkg::BCON_RST;
			st_reg.pre_cnt <= 6'h00;
			st_reg.div_cnt <= 16'h0000;
			st_reg.tick <= 1'b0;
			st_reg.wait_req <= 1'b1;
			st_reg.rdata <= 32'h00000000;
			st_reg.sync_mode <= 1'b0;
			st_reg.wide_div <= 1'b0;
			st_reg.high_speed <= 1'b0;
		end else if (ce_in) begin
			st_reg <= st_next;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign avs_readdata_out = st_reg.rdata;
	assign avs_waitrequest_out = st_reg.wait_req;
	assign bit_tick_out = st_reg.tick;
	assign sync_mode_out = st_reg.sync_mode;
	assign wide_div_out = st_reg.wide_div;
	assign high_speed_out = st_reg.high_speed;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	low_reset_a: assert property (
		@(posedge clk_in) srst_in |=> (st_reg.div_low == 8'h00 && st_reg.div_high == 8'h00))
		else $error("divisor bytes not cleared by reset");

	low_write_a: assert property (
		@(posedge clk_in) disable iff (srst_in)
		(ce_in && wr_low) |=> (st_reg.div_low == $past(avs_writedata_in[7:0])))
		else $error("low divisor write lost");

	high_write_a: assert property (
		@(posedge clk_in) disable iff (srst_in)
		(ce_in && wr_high) |=> (st_reg.div_high == $past(avs_writedata_in[7:0])))
		else $error("high divisor write lost");

	low_restart_a: assert property (
		@(posedge clk_in) disable iff (srst_in)
		(ce_in && wr_low) |=> (st_reg.pre_cnt == 6'h00 && st_reg.div_cnt == 16'h0000
			&& !st_reg.tick))
		else $error("low divisor write did not restart divider");

	high_restart_a: assert property (
		@(posedge clk_in) disable iff (srst_in)
		(ce_in && wr_high) |=> (st_reg.pre_cnt == 6'h00 && st_reg.div_cnt == 16'h0000))
		else $error("high divisor write did not restart divider");

	narrow_div_a: assert property (
		@(posedge clk_in) disable iff (srst_in)
		!st_reg.bcon[3] |-> (eff_div[15:8] == 8'h00 && eff_div[7:0] == st_reg.div_low))
		else $error("high byte used in narrow mode");

	wide_div_a: assert property (
		@(posedge clk_in) disable iff (srst_in)
		st_reg.bcon[3] |-> (eff_div == {st_reg.div_high, st_reg.div_low}))
		else $error("wide divisor is not the byte pair");

	slow_async_a: assert property (
		@(posedge clk_in) disable iff (srst_in)
		(!st_reg.tsc[4] && !st_reg.bcon[3] && !st_reg.tsc[2]) |-> (pre_max == 6'h3F))
		else $error("narrow low speed prescale is not 64");

	wide_async_a: assert property (
		@(posedge clk_in) disable iff (srst_in)
		(!st_reg.tsc[4] && st_reg.bcon[3] && !st_reg.tsc[2]) |-> (pre_max == 6'h0F))
		else $error("wide low speed prescale is not 16");

	sync_pre_a: assert property (
		@(posedge clk_in) disable iff (srst_in)
		st_reg.tsc[4] |-> (pre_max == 6'h03))
		else $error("sync prescale is not 4");

	mode_out_a: assert property (
		@(posedge clk_in) disable iff (srst_in)
		ce_in |=> (sync_mode_out == $past(st_reg.tsc[4]) && high_speed_out == $past(st_reg.tsc[2])
			&& wide_div_out == $past(st_reg.bcon[3])))
		else $error("mode outputs do not follow control bits");

	tick_cause_a: assert property (
		@(posedge clk_in) disable iff (srst_in)
		$rose(bit_tick_out) |-> ($past(pre_end) && $past(div_end) && !$past(wr_low | wr_high)))
		else $error("tick without divider terminal count");

	tick_gap_a: assert property (
		@(posedge clk_in) disable iff (srst_in)
		(ce_in && bit_tick_out) |=> !bit_tick_out [*3])
		else $error("ticks closer than the least prescale");

	// ------------------------------------------------------------
	// register and bus checks
	// ------------------------------------------------------------
	low_read_a: assert property (
		@(posedge clk_in) disable iff (srst_in)
		(ce_in && avs_read_in && st_reg.wait_req && avs_address_in == sbrg_pkg::OFF_DIV_LOW)
		|=> (!avs_waitrequest_out && avs_readdata_out == {24'h000000, $past(st_reg.div_low)}))
		else $error("low divisor read wrong");

	high_read_a: assert property (
		@(posedge clk_in) disable iff (srst_in)
		(ce_in && avs_read_in && st_reg.wait_req && avs_address_in == sbrg_pkg::OFF_DIV_HIGH)
		|=> (!avs_waitrequest_out && avs_readdata_out == {24'h000000, $past(st_reg.div_high)}))
		else $error("high divisor read wrong");

	count_read_a: assert property (
		@(posedge clk_in) disable iff (srst_in)
		(ce_in && avs_read_in && st_reg.wait_req && avs_address_in == sbrg_pkg::OFF_COUNT)
		|=> (avs_readdata_out == {16'h0000, $past(st_reg.div_cnt)}))
		else $error("divider count read wrong");

	answer_once_a: assert property (
		@(posedge clk_in) disable iff (srst_in)
		(ce_in && !avs_waitrequest_out) |=> avs_waitrequest_out)
		else $error("bus answer held longer than one cycle");

	idle_wait_a: assert property (
		@(posedge clk_in) disable iff (srst_in)
		(ce_in && !avs_read_in && !avs_write_in) |=> avs_waitrequest_out)
		else $error("waitrequest low with no request");

	first_wait_a: assert property (
		@(posedge clk_in) disable iff (srst_in)
		(ce_in && (avs_read_in || avs_write_in) && avs_waitrequest_out) |=> !avs_waitrequest_out)
		else $error("request not answered after one wait cycle");

	lane_guard_a: assert property (
		@(posedge clk_in) disable iff (srst_in)
		(ce_in && take && avs_write_in && !avs_byteenable_in[0])
		|=> ($stable(st_reg.div_low) && $stable(st_reg.div_high)))
		else $error("divisor changed by a write without lane zero");

	tsc_write_a: assert property (
		@(posedge clk_in) disable iff (srst_in)
		(ce_in && wr_tsc)
		|=> (st_reg.tsc[4] == $past(avs_writedata_in[4])
			&& st_reg.tsc[2] == $past(avs_writedata_in[2])))
		else $error("control select bits not stored");

	bcon_write_a: assert property (
		@(posedge clk_in) disable iff (srst_in)
		(ce_in && wr_bcon) |=> (st_reg.bcon[3] == $past(avs_writedata_in[3])))
		else $error("wide divisor select not stored");

	reset_out_a: assert property (
		@(posedge clk_in) srst_in |=> (!sync_mode_out && !wide_div_out && !high_speed_out
			&& avs_waitrequest_out && !bit_tick_out))
		else $error("outputs not at rest after reset");

	// ------------------------------------------------------------
	// divider checks
	// ------------------------------------------------------------
	pre_step_a: assert property (
		@(posedge clk_in) disable iff (srst_in)
		(ce_in && !pre_end && !wr_low && !wr_high)
		|=> (st_reg.pre_cnt == $past(st_reg.pre_cnt) + 6'h01 && $stable(st_reg.div_cnt)))
		else $error("prescale counter did not step");

	div_step_a: assert property (
		@(posedge clk_in) disable iff (srst_in)
		(ce_in && pre_end && !div_end && !wr_low && !wr_high)
		|=> (st_reg.pre_cnt == 6'h00 && st_reg.div_cnt == $past(st_reg.div_cnt) + 16'h0001
			&& !bit_tick_out))
		else $error("divisor counter did not step");

	tick_end_a: assert property (
		@(posedge clk_in) disable iff (srst_in)
		(ce_in && pre_end && div_end && !wr_low && !wr_high)
		|=> (bit_tick_out && st_reg.div_cnt == 16'h0000 && st_reg.pre_cnt == 6'h00))
		else $error("terminal count gave no tick");

	freeze_a: assert property (
		@(posedge clk_in) disable iff (srst_in)
		!ce_in |=> $stable(st_reg))
		else $error("state moved while clock enable low");

	hs_narrow_a: assert property (
		@(posedge clk_in) disable iff (srst_in)
		(!st_reg.tsc[4] && !st_reg.bcon[3] && st_reg.tsc[2]) |-> (pre_max == 6'h0F))
		else $error("narrow high speed prescale is not 16");

	sync_wide_a: assert property (
		@(posedge clk_in) disable iff (srst_in)
		(st_reg.tsc[4] && st_reg.bcon[3])
		|-> (pre_max == 6'h03 && eff_div == {st_reg.div_high, st_reg.div_low}))
		else $error("sync wide divisor or prescale wrong");

endmodule

// ---- tb/test_serial_baud_rate_generator.sv ----
/*
 * test_serial_baud_rate_generator: self-checking bench of sbrg_top.
 * assumes the register map and reset values of sbrg_pkg and one wait cycle per access.
 */
`timescale 1ns/1ps

module test_serial_baud_rate_generator;
	logic clk_in = 1'b0;
	logic srst_in = 1'b1;
	logic ce_in = 1'b1;
	logic [sbrg_pkg::ADDR_W-1:0] avs_address_in = '0;
	logic avs_read_in = 1'b0;
	logic avs_write_in = 1'b0;
	logic [31:0] avs_writedata_in = 32'h0;
	logic [3:0] avs_byteenable_in = 4'hF;
	logic [31:0] avs_readdata_out;
	logic avs_waitrequest_out;
	logic bit_tick_out;
	logic sync_mode_out;
	logic wide_div_out;
	logic high_speed_out;
	int fail_count = 0;
	int compares = 0;
	int cycles = 0;

	sbrg_top uut (
		.clk_in(clk_in),
		.srst_in(srst_in),
		.ce_in(ce_in),
		.avs_address_in(avs_address_in),
		.avs_read_in(avs_read_in),
		.avs_write_in(avs_write_in),
		.avs_writedata_in(avs_writedata_in),
		.avs_byteenable_in(avs_byteenable_in),
		.avs_readdata_out(avs_readdata_out),
		.avs_waitrequest_out(avs_waitrequest_out),
		.bit_tick_out(bit_tick_out),
		.sync_mode_out(sync_mode_out),
		.wide_div_out(wide_div_out),
		.high_speed_out(high_speed_out)
	);

	// ------------------------------------------------------------
	// clock, timeout and helpers
	// ------------------------------------------------------------
	always #5 clk_in = ~clk_in;

	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 60000) begin
			fail_count++;
			$display("mismatch at %0t: timeout", $time);
			conclude();
		end
	end

	task automatic conclude();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: %s got %h want %h", $time, msg, got, exp);
		end
	endtask

	task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d,
		input logic [3:0] e, output logic [31:0] q);
		logic [31:0] w;
		w = $urandom;
		w[7:0] = d;
		@(posedge clk_in);
		avs_address_in <= a;
		avs_writedata_in <= w;
		avs_byteenable_in <= e;
		avs_write_in <= wr;
		avs_read_in <= !wr;
		// waitrequest sampled at the edge; the wait has no limit of its own beyond the bench timeout
		do begin
			@(posedge clk_in);
		end while (avs_waitrequest_out !== 1'b0);
		q = avs_readdata_out;
		avs_write_in <= 1'b0;
		avs_read_in <= 1'b0;
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, 4'hF, q);
	endtask

	task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 8'h00, 4'hF, q);
		chk(q, exp, "register read");
	endtask

	// edges until the next tick, with an optional clock-enable stall first
	task automatic measure(input int stall, output int c);
		c = 0;
		if (stall > 0) begin
			ce_in <= 1'b0;
			repeat (stall) @(posedge clk_in);
			ce_in <= 1'b1;
			c = stall;
		end
		do begin
			@(posedge clk_in);
			#1;
			c++;
		end while (bit_tick_out !== 1'b1 && c < 20000);
	endtask

	function automatic int exp_period(input logic s, w, h, input logic [7:0] hi, lo);
		int p;
		int n;
		p = s ? 4 : (w ? (h ? 4 : 16) : (h ? 16 : 64));
		n = w ? int'({hi, lo}) : int'(lo);
		return p * (n + 1);
	endfunction

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		logic [7:0] lo;
		logic [7:0] hi;
		logic [7:0] t;
		logic [7:0] b;
		logic [31:0] q;
		logic s;
		logic w;
		logic h;
		int c;
		int st;
		void'($urandom(32'h95ee9483));
		repeat (5) @(posedge clk_in);
		srst_in <= 1'b0;
		rd_chk(sbrg_pkg::OFF_DIV_LOW, 32'h0);
		rd_chk(sbrg_pkg::OFF_DIV_HIGH, 32'h0);
		rd_chk(sbrg_pkg::OFF_TSC, 32'(sbrg_pkg::TSC_RST));
		rd_chk(sbrg_pkg::OFF_BCON, 32'(sbrg_pkg::BCON_RST));
		rd_chk(5'h14, 32'h0);
		$display("test reset values done");
		lo = $urandom;
		hi = $urandom;
		wr(sbrg_pkg::OFF_DIV_LOW, lo);
		wr(sbrg_pkg::OFF_DIV_HIGH, hi);
		rd_chk(sbrg_pkg::OFF_COUNT, 32'h0);
		rd_chk(sbrg_pkg::OFF_DIV_LOW, 32'(lo));
		rd_chk(sbrg_pkg::OFF_DIV_HIGH, 32'(hi));
		bus(1'b1, sbrg_pkg::OFF_DIV_LOW, ~lo, 4'hE, q);
		rd_chk(sbrg_pkg::OFF_DIV_LOW, 32'(lo));
		wr(5'h14, 8'hFF);
		rd_chk(5'h14, 32'h0);
		$display("test register access done");
		for (int i = 0; i < 8; i++) begin
			s = i[2];
			w = i[1];
			h = i[0];
			lo = 8'($urandom_range(7, 0));
			hi = 8'h01;
			t = (8'($urandom) & 8'hEB) | (8'(s) << sbrg_pkg::TSC_SYNC_BIT);
			t = t | (8'(h) << sbrg_pkg::TSC_HS_BIT);
			b = (8'($urandom) & 8'hF7) | (8'(w) << sbrg_pkg::BCON_WIDE_BIT);
			wr(sbrg_pkg::OFF_TSC, t);
			wr(sbrg_pkg::OFF_BCON, b);
			rd_chk(sbrg_pkg::OFF_TSC, 32'((t & 8'hFD) | 8'h02));
			rd_chk(sbrg_pkg::OFF_BCON, 32'((b & 8'h9B) | 8'h40));
			chk({29'h0, sync_mode_out, wide_div_out, high_speed_out}, {29'h0, s, w, h}, "mode");
			if (i % 2 == 1) begin
				wr(sbrg_pkg::OFF_DIV_LOW, lo);
				wr(sbrg_pkg::OFF_DIV_HIGH, hi);
			end else begin
				wr(sbrg_pkg::OFF_DIV_HIGH, hi);
				wr(sbrg_pkg::OFF_DIV_LOW, lo);
			end
			st = (i == 5) ? 7 : 0;
			measure(st, c);
			chk(32'(c), 32'(exp_period(s, w, h, hi, lo) + st), "first tick");
			measure(0, c);
			chk(32'(c), 32'(exp_period(s, w, h, hi, lo)), "tick period");
			$display("test rate %0d done", i);
		end
		conclude();
	end
endmodule
